// *** ccr_top.sv ***
// channel configuration register bank with decoded field outputs
`timescale 1ns/1ns
module ccr_top
  import ccr_pkg::*;
(
  // clock, reset, enable
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // register access from the management host
  input wire logic WR_I,
  input wire logic [ccr_pkg::PAGE_W-1:0] PAGE_I,
  input wire logic [ccr_pkg::WORD_W-1:0] WDATA_I,
  output logic [ccr_pkg::WORD_W-1:0] RDATA_O,
  // channel status and run pins
  input wire logic [2:0] CH_SEL_I,
  input wire logic RUN_PIN_A_I,
  input wire logic RUN_PIN_B_I,
  input wire logic CH_ON_I,
  input wire logic RISE_DONE_I,
  input wire logic FAULT_OFF_I,
  input wire logic WARN_HIT_I,
  input wire logic TARGET_REACHED_I,
  input wire logic SOFT_DONE_I,
  // decoded controls for the selected channel
  output logic RUN_O,
  output logic FAST_SERVO_EN_O,
  output logic SUP_LOW_RES_O,
  output logic ADC_HIRES_O,
  output logic DAC_GAIN_HI_O,
  output logic DAC_POL_NONINV_O,
  output logic SERVO_REQ_O,
  output logic DAC_CONNECT_O,
  output logic SOFT_CONNECT_O,
  output logic DAC_WRITE_OK_O,
  output logic [3:0] OUT_EN_DRIVE_O
);
  import ccr_pkg::*;

  logic [15:0] rword;
  logic [15:0] sword;
  ccr_drive_t drive;
  ccr_cfg_if cfg ();
  ccr_dac_mode_t mode;
  logic active;
  logic live;
  logic next_run, next_fast, next_sup, next_adc, next_gain, next_pol;
  logic next_servo, next_conn, next_soft, next_dwok;
  logic [15:0] next_rdata;
  logic [3:0] next_drive;

  ccr_store u_store (
    .clk(CORE_CLK_I),
    .rst(RST_I),
    .ce(CE_I),
    .wr(WR_I),
    .page(PAGE_I),
    .wdata(WDATA_I),
    .sel(CH_SEL_I),
    .rword(rword),
    .sword(sword)
  );

  assign cfg.ch = CH_SEL_I;
  assign cfg.word = sword;

  ccr_drive u_drive (
    .cfg(cfg),
    .on(CH_ON_I),
    .fault_off(FAULT_OFF_I),
    .drive(drive)
  );

  assign mode = ccr_dac_mode_t'(sword[B_MODE_HI:B_MODE_LO]);
  // mode field is honoured only after rise time on an on channel
  assign active = CH_ON_I && RISE_DONE_I;
  // outputs follow the word only on enabled edges outside reset; checks key on this
  assign live = CE_I && !RST_I;

  // next values of all decoded outputs
  always_comb
  begin
    next_rdata = rword & CFG_WMASK;
    next_run = sword[B_RUN_SEL] ? RUN_PIN_B_I : RUN_PIN_A_I;
    next_fast = !sword[B_FAST_OFF];
    next_sup = sword[B_SUP_LOW];
    next_adc = sword[B_ADC_HI] && CH_SEL_I[0];
    next_gain = sword[B_GAIN];
    next_pol = sword[B_POL];
    next_servo = 1'b0;
    next_conn = 1'b0;
    next_soft = 1'b0;
    next_dwok = 1'b0;
    if (active)
    begin
      unique case (mode)
        DAC_SERVO:
        begin
          // servo until target, then continuous or on warning
          next_servo = !TARGET_REACHED_I || sword[B_SERVO_CONT]
            || (sword[B_SERVO_WARN] && WARN_HIT_I);
          next_soft = !SOFT_DONE_I;
          next_conn = SOFT_DONE_I;
        end
        DAC_OFF:
        begin
          next_conn = 1'b0;
        end
        DAC_DIRECT:
        begin
          // stored dac value is undefined after reset; host must load it
          next_conn = 1'b1;
          next_dwok = 1'b1;
        end
        DAC_SOFT:
        begin
          next_soft = !SOFT_DONE_I;
          next_conn = SOFT_DONE_I;
          next_dwok = SOFT_DONE_I;
        end
      endcase
    end
    next_drive = drive;
  end

  // all outputs registered; pin outputs stay in the fast pull-down at reset
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      RDATA_O <= 16'h0000;
      RUN_O <= 1'b0;
      FAST_SERVO_EN_O <= 1'b0;
      SUP_LOW_RES_O <= 1'b0;
      ADC_HIRES_O <= 1'b0;
      DAC_GAIN_HI_O <= 1'b0;
      DAC_POL_NONINV_O <= 1'b0;
      SERVO_REQ_O <= 1'b0;
      DAC_CONNECT_O <= 1'b0;
      SOFT_CONNECT_O <= 1'b0;
      DAC_WRITE_OK_O <= 1'b0;
      OUT_EN_DRIVE_O <= DRV_FAST_DN;
    end
    else if (CE_I)
    begin
      RDATA_O <= next_rdata;
      RUN_O <= next_run;
      FAST_SERVO_EN_O <= next_fast;
      SUP_LOW_RES_O <= next_sup;
      ADC_HIRES_O <= next_adc;
      DAC_GAIN_HI_O <= next_gain;
      DAC_POL_NONINV_O <= next_pol;
      SERVO_REQ_O <= next_servo;
      DAC_CONNECT_O <= next_conn;
      SOFT_CONNECT_O <= next_soft;
      DAC_WRITE_OK_O <= next_dwok;
      OUT_EN_DRIVE_O <= next_drive;
    end
  end

  property p_rd_reserved;
    @(posedge CORE_CLK_I) disable iff (RST_I) RDATA_O[15:12] == 4'h0;
  endproperty
  a_rd_reserved: assert property (p_rd_reserved) else $error("reserved read nonzero");

  property p_fast;
    @(posedge CORE_CLK_I) disable iff (RST_I) live |=> FAST_SERVO_EN_O == !$past(sword[11]);
  endproperty
  a_fast: assert property (p_fast) else $error("fast servo wrong");

  property p_sup;
    @(posedge CORE_CLK_I) disable iff (RST_I) live |=> SUP_LOW_RES_O == $past(sword[10]);
  endproperty
  a_sup: assert property (p_sup) else $error("supervisor scale wrong");

  property p_adc_even;
    @(posedge CORE_CLK_I) disable iff (RST_I) (live && !CH_SEL_I[0]) |=> !ADC_HIRES_O;
  endproperty
  a_adc_even: assert property (p_adc_even) else $error("even channel fine adc");

  property p_adc_odd;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && CH_SEL_I[0]) |=> ADC_HIRES_O == $past(sword[B_ADC_HI]);
  endproperty
  a_adc_odd: assert property (p_adc_odd) else $error("odd channel adc wrong");

  property p_run;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && sword[8]) |=> RUN_O == $past(RUN_PIN_B_I);
  endproperty
  a_run: assert property (p_run) else $error("run pin b not used");

  property p_run_a;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && !sword[B_RUN_SEL]) |=> RUN_O == $past(RUN_PIN_A_I);
  endproperty
  a_run_a: assert property (p_run_a) else $error("run pin a not used");

  property p_servo_off_mode;
    @(posedge CORE_CLK_I) disable iff (RST_I) (live && mode != DAC_SERVO) |=> !SERVO_REQ_O;
  endproperty
  a_servo_off_mode: assert property (p_servo_off_mode) else $error("servo outside mode 00");

  property p_servo_cont;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && active && mode == DAC_SERVO && sword[B_SERVO_CONT]) |=> SERVO_REQ_O;
  endproperty
  a_servo_cont: assert property (p_servo_cont) else $error("continuous servo stopped");

  property p_servo_stop;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && active && mode == DAC_SERVO && TARGET_REACHED_I
        && !sword[B_SERVO_CONT] && !sword[B_SERVO_WARN]) |=> !SERVO_REQ_O;
  endproperty
  a_servo_stop: assert property (p_servo_stop) else $error("servo kept after target");

  property p_warn;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && active && mode == DAC_SERVO && sword[6] && WARN_HIT_I) |=> SERVO_REQ_O;
  endproperty
  a_warn: assert property (p_warn) else $error("no re-servo on warning");

  property p_warn_quiet;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && active && mode == DAC_SERVO && TARGET_REACHED_I
        && !sword[B_SERVO_CONT] && !WARN_HIT_I) |=> !SERVO_REQ_O;
  endproperty
  a_warn_quiet: assert property (p_warn_quiet) else $error("re-servo without warning");

  property p_inactive;
    @(posedge CORE_CLK_I) disable iff (RST_I) (live && !active) |=> !DAC_CONNECT_O;
  endproperty
  a_inactive: assert property (p_inactive) else $error("dac connected before rise");

  property p_inactive_all;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && !active) |=> !SERVO_REQ_O && !SOFT_CONNECT_O && !DAC_WRITE_OK_O;
  endproperty
  a_inactive_all: assert property (p_inactive_all) else $error("dac busy before rise");

  property p_mode_off;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && active && mode == DAC_OFF) |=> !DAC_CONNECT_O && !SOFT_CONNECT_O;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("dac used in mode 01");

  property p_direct;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && active && mode == DAC_DIRECT) |=> DAC_CONNECT_O && !SOFT_CONNECT_O;
  endproperty
  a_direct: assert property (p_direct) else $error("direct connect missing");

  property p_soft;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && active && mode == DAC_SOFT && !SOFT_DONE_I) |=> !DAC_WRITE_OK_O;
  endproperty
  a_soft: assert property (p_soft) else $error("dac write allowed early");

  property p_soft_done;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && active && mode == DAC_SOFT && SOFT_DONE_I)
        |=> DAC_CONNECT_O && DAC_WRITE_OK_O && !SOFT_CONNECT_O;
  endproperty
  a_soft_done: assert property (p_soft_done) else $error("soft connect not finished");

  property p_hi_ch_up;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && CH_SEL_I[2] && CH_ON_I) |=> OUT_EN_DRIVE_O == DRV_HIZ;
  endproperty
  a_hi_ch_up: assert property (p_hi_ch_up) else $error("weak pull-up on upper ch");

  property p_weak_up;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && CH_ON_I && !CH_SEL_I[2] && sword[B_WPU]) |=> OUT_EN_DRIVE_O == DRV_WEAK_UP;
  endproperty
  a_weak_up: assert property (p_weak_up) else $error("weak pull-up missing");

  property p_fault_fast;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && !CH_ON_I && FAULT_OFF_I) |=> OUT_EN_DRIVE_O == DRV_FAST_DN;
  endproperty
  a_fault_fast: assert property (p_fault_fast) else $error("no fast pull-down on fault");

  property p_weak_dn;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && !CH_ON_I && !CH_SEL_I[2] && sword[B_WPD] && !FAULT_OFF_I)
        |=> OUT_EN_DRIVE_O == DRV_WEAK_DN;
  endproperty
  a_weak_dn: assert property (p_weak_dn) else $error("weak pull-down missing");

  property p_hi_ch_dn;
    @(posedge CORE_CLK_I) disable iff (RST_I)
      (live && !CH_ON_I && CH_SEL_I[2]) |=> OUT_EN_DRIVE_O == DRV_FAST_DN;
  endproperty
  a_hi_ch_dn: assert property (p_hi_ch_dn) else $error("weak pull-down on upper ch");

  property p_gain;
    @(posedge CORE_CLK_I) disable iff (RST_I) live |=> DAC_GAIN_HI_O == $past(sword[1]);
  endproperty
  a_gain: assert property (p_gain) else $error("dac gain wrong");

  property p_pol;
    @(posedge CORE_CLK_I) disable iff (RST_I) live |=> DAC_POL_NONINV_O == $past(sword[0]);
  endproperty
  a_pol: assert property (p_pol) else $error("dac polarity wrong");

  c_direct: cover property (@(posedge CORE_CLK_I) active && mode == DAC_DIRECT);
  c_soft_done: cover property (@(posedge CORE_CLK_I) active && mode == DAC_SOFT && SOFT_DONE_I);
  c_weak_dn: cover property (@(posedge CORE_CLK_I) OUT_EN_DRIVE_O == DRV_WEAK_DN);
  c_write: cover property (@(posedge CORE_CLK_I) CE_I && WR_I && PAGE_I == 3'h7);
  c_warn: cover property (@(posedge CORE_CLK_I) active && mode == DAC_SERVO && WARN_HIT_I);
endmodule : ccr_top

// *** ccr_pkg.sv ***
// package of constants, field positions and types for the channel configuration bank
package ccr_pkg;
  localparam int NUM_CH = 8;
  localparam int PAGE_W = 3;
  localparam int WORD_W = 16;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] CFG_WMASK = 16'h0FFF;
  localparam int B_FAST_OFF = 11;
  localparam int B_SUP_LOW = 10;
  localparam int B_ADC_HI = 9;
  localparam int B_RUN_SEL = 8;
  localparam int B_SERVO_CONT = 7;
  localparam int B_SERVO_WARN = 6;
  localparam int B_MODE_HI = 5;
  localparam int B_MODE_LO = 4;
  localparam int B_WPU = 3;
  localparam int B_WPD = 2;
  localparam int B_GAIN = 1;
  localparam int B_POL = 0;
  localparam logic [2:0] FIRST_LOW_DRIVE_CH = 3'h4;
  typedef enum logic [1:0]
  {
    DAC_SERVO = 2'h0,
    DAC_OFF = 2'h1,
    DAC_DIRECT = 2'h2,
    DAC_SOFT = 2'h3
  } ccr_dac_mode_t;
  // enable pin drive: one-hot, off-fast, off-weak, on-weak-up, on-tristate
  typedef enum logic [3:0]
  {
    DRV_FAST_DN = 4'h1,
    DRV_WEAK_DN = 4'h2,
    DRV_WEAK_UP = 4'h4,
    DRV_HIZ = 4'h8
  } ccr_drive_t;
endpackage : ccr_pkg

// *** ccr_cfg_if.sv ***
// interface carrying the selected channel's number and raw configuration word between modules
`timescale 1ns/1ns
interface ccr_cfg_if;
  import ccr_pkg::*;
  logic [2:0] ch;
  logic [15:0] word;
  modport src (output ch, output word);
  modport dst (input ch, input word);
endinterface : ccr_cfg_if

// *** ccr_store.sv ***
// per-channel configuration word storage, paged writes and reads
`timescale 1ns/1ns
module ccr_store
  import ccr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr,
  input wire logic [2:0] page,
  input wire logic [15:0] wdata,
  input wire logic [2:0] sel,
  output logic [15:0] rword,
  output logic [15:0] sword
);
  logic [15:0] mem [NUM_CH];
  logic [15:0] next_mem [NUM_CH];

  // only addressed page changes; reserved bits masked away
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      next_mem[i] = mem[i];
    end
    if (wr)
    begin
      next_mem[page] = wdata & CFG_WMASK;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        mem[i] <= CFG_RESET;
      end
    end
    else if (ce)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        mem[i] <= next_mem[i];
      end
    end
  end

  assign rword = mem[page];
  assign sword = mem[sel];

  property p_reserved_zero;
    @(posedge clk) disable iff (rst) rword[15:12] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

  property p_write_lands;
    @(posedge clk) disable iff (rst)
      (ce && wr) |=> mem[$past(page)] == ($past(wdata) & CFG_WMASK);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not stored");

  property p_other_page_kept;
    @(posedge clk) disable iff (rst)
      (ce && wr && page != 3'h0) |=> $stable(mem[0]);
  endproperty
  a_other_page_kept: assert property (p_other_page_kept) else $error("other page changed");
endmodule : ccr_store

// *** ccr_drive.sv ***
// supply-enable pin drive selection for one channel
`timescale 1ns/1ns
module ccr_drive
  import ccr_pkg::*;
(
  ccr_cfg_if.dst cfg,
  input wire logic on,
  input wire logic fault_off,
  output ccr_drive_t drive
);
  logic low_ch;

  // channels 4-7 lack the weak drivers
  assign low_ch = cfg.ch < FIRST_LOW_DRIVE_CH;

  always_comb
  begin
    if (on)
    begin
      drive = (cfg.word[B_WPU] && low_ch) ? DRV_WEAK_UP : DRV_HIZ;
    end
    else if (cfg.word[B_WPD] && low_ch && !fault_off)
    begin
      drive = DRV_WEAK_DN;
    end
    else
    begin
      drive = DRV_FAST_DN;
    end
  end
endmodule : ccr_drive

// *** ccr_host.sv ***
// host-side model that writes and addresses the paged configuration words
`timescale 1ns/1ns
module ccr_host
  import ccr_pkg::*;
(
  // clock
  input wire logic clk_i,
  // register access toward the device
  output logic wr_o,
  output logic [ccr_pkg::PAGE_W-1:0] page_o,
  output logic [ccr_pkg::WORD_W-1:0] wdata_o
);
  initial
  begin
    wr_o = 1'b0;
    page_o = 3'h0;
    wdata_o = 16'h0000;
  end

  // one-cycle strobe; data inverted afterwards so nothing leans on a stale bus
  task put(input logic [2:0] p, input logic [15:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    page_o <= p;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : put

  // address a page for readback only
  task sel(input logic [2:0] p);
    @(posedge clk_i);
    page_o <= p;
  endtask : sel
endmodule : ccr_host

// *** tb_top.sv ***
// self-checking bench for the channel configuration bank
`timescale 1ns/1ns
module tb_top;
  import ccr_pkg::*;
  typedef struct packed
  {
    logic [15:0] w;
    logic [2:0] ch;
    logic [7:0] in;
    logic [13:0] exp;
  } ccr_row_t;
  logic clk, rst, ce, wr;
  logic [2:0] page, ch_sel;
  logic [15:0] wdata, rdata;
  logic [7:0] ins;
  wire [13:0] outs;
  int error_cnt = 0;
  int samples_checked = 0;
  // inputs: run_a run_b on rise fault warn target soft_done
  ccr_row_t rows [13] = '{
    '{16'h0000, 3'h0, 8'hB0, 14'h30A8}, '{16'hFFFF, 3'h1, 8'h73, 14'h2F54},
    '{16'h0E20, 3'h2, 8'h30, 14'h0858}, '{16'h0010, 3'h3, 8'h70, 14'h1008},
    '{16'h000C, 3'h4, 8'h30, 14'h10A8}, '{16'h000C, 3'h5, 8'h00, 14'h1001},
    '{16'h0004, 3'h0, 8'h00, 14'h1002}, '{16'h0004, 3'h0, 8'h08, 14'h1001},
    '{16'h0080, 3'h2, 8'h32, 14'h10A8}, '{16'h0040, 3'h2, 8'h37, 14'h10C8},
    '{16'h0040, 3'h2, 8'h33, 14'h1048}, '{16'h0030, 3'h3, 8'h30, 14'h1028},
    '{16'h0020, 3'h1, 8'h20, 14'h1008}};

  ccr_host u_host (.clk_i(clk), .wr_o(wr), .page_o(page), .wdata_o(wdata));

  ccr_top u_dut (
    .CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce), .WR_I(wr), .PAGE_I(page),
    .WDATA_I(wdata), .RDATA_O(rdata), .CH_SEL_I(ch_sel),
    .RUN_PIN_A_I(ins[7]), .RUN_PIN_B_I(ins[6]), .CH_ON_I(ins[5]),
    .RISE_DONE_I(ins[4]), .FAULT_OFF_I(ins[3]), .WARN_HIT_I(ins[2]),
    .TARGET_REACHED_I(ins[1]), .SOFT_DONE_I(ins[0]),
    .RUN_O(outs[13]), .FAST_SERVO_EN_O(outs[12]), .SUP_LOW_RES_O(outs[11]),
    .ADC_HIRES_O(outs[10]), .DAC_GAIN_HI_O(outs[9]), .DAC_POL_NONINV_O(outs[8]),
    .SERVO_REQ_O(outs[7]), .DAC_CONNECT_O(outs[6]), .SOFT_CONNECT_O(outs[5]),
    .DAC_WRITE_OK_O(outs[4]), .OUT_EN_DRIVE_O(outs[3:0]));

  // compare and count
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // single exit point for normal end and watchdog
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchdog well beyond the roughly 100 cycles the tests take
  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    ch_sel = 3'h0;
    ins = 8'h00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // table: write page, select it, check decoded fields and readback
    foreach (rows[i])
    begin
      u_host.put(rows[i].ch, rows[i].w);
      @(posedge clk);
      ch_sel <= rows[i].ch;
      ins <= rows[i].in;
      repeat (2) @(posedge clk);
      #1;
      check("fields", {2'h0, outs}, {2'h0, rows[i].exp});
      check("readback", rdata, rows[i].w & 16'h0FFF);
    end
    // a write to another page leaves page one alone
    u_host.put(3'h6, 16'h0ABC);
    u_host.sel(3'h1);
    repeat (2) @(posedge clk);
    #1;
    check("other page", rdata, 16'h0020);
    // clock enable low blocks a write
    @(posedge clk);
    ce <= 1'b0;
    u_host.put(3'h1, 16'h0FFF);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("frozen", rdata, 16'h0020);
    // reset in mid-run clears words and outputs, except the enable drive, which returns to fast pull-down
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    check("reset fields", {2'h0, outs}, 16'h0001);
    u_host.sel(3'h6);
    repeat (2) @(posedge clk);
    #1;
    check("reset word", rdata, 16'h0000);
    end_sim();
  end
endmodule : tb_top
